// ### rtl/eq_band_gain_serial_loader.v
`timescale 1ns/1ps
`include "eq_band_gain_regs.vh"
module eq_band_gain_serial_loader #(
    parameter BANDS = 11
) (
    // System clock and reset
    input wire i_clk,
    input wire i_rst,
    // Serial link pins
    input wire i_cs_n,
    input wire i_serial_clk,
    input wire i_serial_data_in,
    // Latched gains: {sign, magnitude} per band, band 1 lowest
    output reg [4*BANDS-1:0] o_gain_left,
    output reg [4*BANDS-1:0] o_gain_right,
    // Status
    output reg o_initialized,
    output reg o_word_done,
    output reg o_word_rejected
);

    localparam integer SETUP_CYC = `SETUP_CYC;

    // Two-stage synchronisers for the three pins
    reg cs_m_r, cs_s_r, cs_d_r;
    reg sck_m_r, sck_s_r, sck_d_r;
    reg sdi_m_r, sdi_s_r;

    always @(posedge i_clk) begin
        if (i_rst) begin
            cs_m_r <= 1'b1;
            cs_s_r <= 1'b1;
            cs_d_r <= 1'b1;
            sck_m_r <= 1'b0;
            sck_s_r <= 1'b0;
            sck_d_r <= 1'b0;
            sdi_m_r <= 1'b0;
            sdi_s_r <= 1'b0;
        end else begin
            cs_m_r <= i_cs_n;
            cs_s_r <= cs_m_r;
            cs_d_r <= cs_s_r;
            sck_m_r <= i_serial_clk;
            sck_s_r <= sck_m_r;
            sck_d_r <= sck_s_r;
            sdi_m_r <= i_serial_data_in;
            sdi_s_r <= sdi_m_r;
        end
    end

    wire sck_rise = sck_s_r & ~sck_d_r;
    wire cs_rise = cs_s_r & ~cs_d_r;

    // Data stability counter: how long data has held its level
    reg [7:0] stable_cnt_r;
    reg sdi_prev_r;

    always @(posedge i_clk) begin
        if (i_rst) begin
            stable_cnt_r <= 8'h00;
            sdi_prev_r <= 1'b0;
        end else begin
            sdi_prev_r <= sdi_s_r;
            if (sdi_s_r != sdi_prev_r) begin
                // The change cycle counts as one, so a 1 us gap reads as SETUP_CYC
                stable_cnt_r <= 8'h01;
            end else if (stable_cnt_r != 8'hff) begin
                stable_cnt_r <= stable_cnt_r + 8'h01;
            end
        end
    end

    // Shift register, LSB first, only while chip select is low
    reg [`WORD_BITS-1:0] shift_r;
    reg [3:0] bit_cnt_r;
    reg setup_err_r;

    always @(posedge i_clk) begin
        if (i_rst) begin
            shift_r <= {`WORD_BITS{1'b0}};
            bit_cnt_r <= 4'h0;
            setup_err_r <= 1'b0;
        end else if (cs_rise) begin
            // Each frame starts from bit zero again
            bit_cnt_r <= 4'h0;
            setup_err_r <= 1'b0;
        end else if (!cs_s_r && sck_rise) begin
            // Newest bit enters at the top so the first ends at bit 0
            shift_r <= {sdi_s_r, shift_r[`WORD_BITS-1:1]};
            if (bit_cnt_r != 4'hf) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            // Sampled too soon after a data change; flagged, not dropped
            if (stable_cnt_r < SETUP_CYC[7:0]) begin
                setup_err_r <= 1'b1;
            end
        end
    end

    // Field decode of the assembled word
    wire ch_right = shift_r[`CH_RIGHT_BIT];
    wire ch_left = shift_r[`CH_LEFT_BIT];
    wire [3:0] band = shift_r[`BAND_MSB:`BAND_LSB];
    wire [2:0] mag = shift_r[`MAG_MSB:`MAG_LSB];
    wire sign = shift_r[`SIGN_BIT];
    wire is_flat = (shift_r == `FLAT_WORD);
    wire full_word = (bit_cnt_r == `WORD_BITS);
    wire band_ok = (band >= `BAND_FIRST) && (band <= `BAND_LAST);
    wire mag_ok = (mag <= `MAG_MAX);
    wire ch_ok = ch_right | ch_left;
    // Zero magnitude is stored as plain zero, whatever the sign
    wire [3:0] gain_code = (mag == 3'h0) ? `GAIN_FLAT : {sign, mag};
    wire word_ok = full_word && band_ok && mag_ok && ch_ok;

    // Load strobes, taken on chip select rising
    wire flat_ld = cs_rise && full_word && is_flat;
    wire ld_right = cs_rise && !is_flat && word_ok && ch_right;
    wire ld_left = cs_rise && !is_flat && word_ok && ch_left;

    wire [4*BANDS-1:0] bank_left;
    wire [4*BANDS-1:0] bank_right;

    // Two banks of eleven latches, 22 in all
    eq_gain_latch_bank #(.BANDS(BANDS)) u_left (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_load(ld_left),
        .i_flat(flat_ld),
        .i_band(band),
        .i_gain(gain_code),
        .o_gains(bank_left)
    );

    eq_gain_latch_bank #(.BANDS(BANDS)) u_right (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_load(ld_right),
        .i_flat(flat_ld),
        .i_band(band),
        .i_gain(gain_code),
        .o_gains(bank_right)
    );

    // Outputs registered; contents only meaningful once initialized
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_gain_left <= {4*BANDS{1'b0}};
            o_gain_right <= {4*BANDS{1'b0}};
            o_initialized <= 1'b0;
            o_word_done <= 1'b0;
            o_word_rejected <= 1'b0;
        end else begin
            o_gain_left <= bank_left;
            o_gain_right <= bank_right;
            if (flat_ld) begin
                o_initialized <= 1'b1;
            end
            o_word_done <= cs_rise;
            o_word_rejected <= cs_rise && !flat_ld && (!word_ok || setup_err_r);
        end
    end

endmodule // eq_band_gain_serial_loader

// ### rtl/eq_band_gain_regs.vh
`ifndef EQ_BAND_GAIN_REGS_VH
`define EQ_BAND_GAIN_REGS_VH

// Frame layout, first bit received is bit 0
`define WORD_BITS 10
`define CH_RIGHT_BIT 0
`define CH_LEFT_BIT 1
`define BAND_LSB 2
`define BAND_MSB 5
`define MAG_LSB 6
`define MAG_MSB 8
`define SIGN_BIT 9

// Field codes
`define BAND_FIRST 4'h1
`define BAND_LAST 4'hb
`define MAG_MAX 3'h6
`define FLAT_WORD 10'h3ff
`define GAIN_FLAT 4'h0
`define NUM_BANDS 11

// Timing: system clock period and least data setup, in ns
`define CLK_PERIOD_NS 10
`define SETUP_NS 1000
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/eq_gain_latch_bank.v
`timescale 1ns/1ps
// One channel's bank of per-band gain latches
module eq_gain_latch_bank #(
    parameter BANDS = 11
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst,
    // Update request
    input wire i_load,
    input wire i_flat,
    input wire [3:0] i_band,
    input wire [3:0] i_gain,
    // Latched gains, band 1 in the low nibble
    output wire [4*BANDS-1:0] o_gains
);

    reg [4*BANDS-1:0] gains_r;
    integer k;

    // Only the addressed band moves; a flat word clears all
    always @(posedge i_clk) begin
        if (i_rst) begin
            gains_r <= {4*BANDS{1'b0}};
        end else begin
            for (k = 0; k < BANDS; k = k + 1) begin
                if (i_flat) begin
                    gains_r[4*k +: 4] <= 4'h0;
                end else if (i_load && (i_band == k + 1)) begin
                    gains_r[4*k +: 4] <= i_gain;
                end
            end
        end
    end

    assign o_gains = gains_r;

endmodule // eq_gain_latch_bank

// ### bench/eq_host_model.sv
`timescale 1ns/1ps
// Controller on the far side of the serial pins
module eq_host_model (
    // Pacing clock
    input wire logic i_clk,
    // Serial pins
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_data
);
    // Link clock idles low between frames
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_data = 1'b0;
    end
    // One frame of n bits, bit 0 first, 1 us setup and hold
    task automatic send(input logic [9:0] w, input int n);
        @(posedge i_clk);
        #1 o_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            o_data = w[i];
            #1000 o_sclk = 1'b1;
            #40 o_sclk = 1'b0;
            #1000;
        end
        o_cs_n = 1'b1;
        o_data = ~o_data; // Released line shows no stale bit
    endtask
endmodule // eq_host_model

// ### bench/eq_loader_monitor.sv
`timescale 1ns/1ps
// Checks the loader status and gain outputs
module eq_loader_monitor #(
    parameter BANDS = 11
) (
    // Clock, reset, pins
    input logic i_clk,
    input logic i_rst,
    input logic i_cs_n,
    input logic i_serial_clk,
    input logic i_serial_data_in,
    // Outputs
    input logic [4*BANDS-1:0] o_gain_left,
    input logic [4*BANDS-1:0] o_gain_right,
    input logic o_initialized,
    input logic o_word_done,
    input logic o_word_rejected
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Status pulses tied to chip select rises
    property p_rej; o_word_rejected |-> o_word_done; endproperty
    property p_pulse; o_word_done |=> !o_word_done; endproperty
    property p_cs; o_word_done |-> $past(i_cs_n, 3); endproperty
    property p_quiet; i_cs_n [*8] |=> !o_word_done; endproperty
    a_rej: assert property (p_rej) else $error("reject without done");
    a_pulse: assert property (p_pulse) else $error("done too long");
    a_cs: assert property (p_cs) else $error("done without select rise");
    a_quiet: assert property (p_quiet) else $error("done while idle");
    // Gains move only around a finished word
    property p_left;
        $changed(o_gain_left) |-> o_word_done || $past(o_word_done) || $past(o_word_done, 2);
    endproperty
    property p_right;
        $changed(o_gain_right) |-> o_word_done || $past(o_word_done) || $past(o_word_done, 2);
    endproperty
    a_left: assert property (p_left) else $error("left gain moved");
    a_right: assert property (p_right) else $error("right gain moved");
    // Flat word sets and keeps the ready flag
    property p_hold; o_initialized |=> o_initialized; endproperty
    property p_flat; $rose(o_initialized) |-> ##[0:2] (o_gain_left == '0 && o_gain_right == '0);
    endproperty
    a_hold: assert property (p_hold) else $error("init flag dropped");
    a_flat: assert property (p_flat) else $error("init without flat");
    c_ok: cover property (o_word_done && !o_word_rejected);
    c_rej: cover property (o_word_rejected);
    c_init: cover property ($rose(o_initialized));
endmodule // eq_loader_monitor

// ### bench/eq_band_gain_serial_loader_tb.sv
`timescale 1ns/1ps
module eq_band_gain_serial_loader_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    wire cs_n, sclk, sdi, init, done, rej;
    wire [43:0] gl, gr;
    logic [43:0] el = '0;
    logic [43:0] er = '0;
    int bad_count = 0;
    int n_checks = 0;
    // 100 MHz clock
    always #5 i_clk = ~i_clk;
    eq_host_model u_host (.i_clk(i_clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_data(sdi));
    eq_band_gain_serial_loader u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n),
        .i_serial_clk(sclk), .i_serial_data_in(sdi), .o_gain_left(gl), .o_gain_right(gr),
        .o_initialized(init), .o_word_done(done), .o_word_rejected(rej));
    task automatic chk_gain(input logic [43:0] g, input logic [43:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t gains %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task final_report();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Send a frame, wait for done, then update and compare the expected latches
    task automatic word(input logic [9:0] w, input int n, input logic rj);
        int k;
        int b;
        logic [3:0] g;
        u_host.send(w, n);
        for (k = 0; k < 60 && done !== 1'b1; k++) begin
            @(posedge i_clk);
            #1;
        end
        if (k == 60) begin
            bad_count++;
            $display("ERROR %0t no done", $time);
            final_report();
        end
        chk_bit(rej, rj);
        b = w[5:2] - 1;
        g = (w[8:6] == 3'h0) ? 4'h0 : w[9:6];
        if (!rj && w == 10'h3ff) begin
            el = '0;
            er = '0;
        end else if (!rj) begin
            if (w[0]) er[4*b +: 4] = g;
            if (w[1]) el[4*b +: 4] = g;
        end
        repeat (4) @(posedge i_clk);
        chk_gain(gl, el);
        chk_gain(gr, er);
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge i_clk);
        #1 i_rst = 1'b0;
        chk_bit(init, 1'b0);
        word(10'h3ff, 10, 1'b0);
        chk_bit(init, 1'b1);
        for (int i = 0; i < 13; i++)
            word({i > 6, i > 6 ? 3'(i - 6) : 3'(i), 4'h2, 2'h1}, 10, 1'b0);
        for (int i = 1; i < 12; i++)
            word({1'b0, 3'(i % 7), 4'(i), 2'h2}, 10, 1'b0);
        word({1'b1, 3'h6, 4'hb, 2'h3}, 10, 1'b0);
        word({1'b0, 3'h7, 4'h3, 2'h1}, 10, 1'b1);
        word({1'b0, 3'h1, 4'h0, 2'h3}, 10, 1'b1);
        word({1'b0, 3'h1, 4'hc, 2'h3}, 10, 1'b1);
        word({1'b0, 3'h1, 4'h3, 2'h0}, 10, 1'b1);
        word(10'h3ff, 9, 1'b1);
        word(10'h3ff, 10, 1'b0);
        final_report();
    end
endmodule // eq_band_gain_serial_loader_tb
bind eq_band_gain_serial_loader eq_loader_monitor #(.BANDS(BANDS)) u_mon (.i_clk(i_clk),
    .i_rst(i_rst), .i_cs_n(i_cs_n), .i_serial_clk(i_serial_clk),
    .i_serial_data_in(i_serial_data_in), .o_gain_left(o_gain_left),
    .o_gain_right(o_gain_right), .o_initialized(o_initialized),
    .o_word_done(o_word_done), .o_word_rejected(o_word_rejected));
